// file: core/ccl_comparator_control.sv
// Digital control of one analog comparator and its internal reference
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Result high when plus input exceeds minus
// - Inversion bit flips result before use
// - Result read at control bit six, unwritable
// - Switch bit picks minus source in 110/101
// - Three-bit mode field selects eight modes
// - Three modes drive result onto output pin
// - Direction bit low enables output pin driver
// - Analog pins read zero from port data
// - Reference: 32 settings, two ranges of 16
// - Range one: code over 24 of supply
// - Range zero: quarter plus code over 32
// - Reference connected in four modes only
// - Flag on change; control access ends mismatch
// - Reference enable bit powers reference circuit
// - Reset: mode 000, reference off
module ccl_comparator_control
  import ccl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic compare_raw,
  input wire logic [5:0] pin_in,
  output logic comparator_on,
  output logic [1:0] plus_sel,
  output logic [1:0] minus_sel,
  output logic ref_connect,
  output logic reference_power_enable,
  output logic reference_range_select,
  output logic [3:0] reference_level_code,
  output logic [6:0] internal_reference_level,
  output logic [2:0] analog_pins,
  output logic result_output_pin,
  output logic result_output_pin_oe,
  output logic irq
);
  import ccl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic inv_ff;
  logic nxt_inv;
  logic switch_ff;
  logic nxt_switch;
  logic [2:0] mode_ff;
  logic [2:0] nxt_mode;
  logic ref_power_ff;
  logic nxt_ref_power;
  logic ref_range_ff;
  logic nxt_ref_range;
  logic [3:0] ref_code_ff;
  logic [3:0] nxt_ref_code;
  logic [5:0] dir_ff;
  logic [5:0] nxt_dir;
  logic stat_ff;
  logic nxt_stat;
  logic ien_ff;
  logic nxt_ien;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Comparator result and the copy held since the last control access
  logic result_ff;
  logic nxt_result;
  logic seen_ff;
  logic nxt_seen;

  // Registered outputs
  logic on_ff;
  logic nxt_on;
  logic [1:0] plus_ff;
  logic [1:0] nxt_plus;
  logic [1:0] minus_ff;
  logic [1:0] nxt_minus;
  logic ref_conn_ff;
  logic nxt_ref_conn;
  logic [6:0] level_ff;
  logic [6:0] nxt_level;
  logic [2:0] analog_ff;
  logic [2:0] nxt_analog;
  logic pin_ff;
  logic nxt_pin;
  logic pin_oe_ff;
  logic nxt_pin_oe;
  logic irq_ff;
  logic nxt_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic [9:0] entry;
  logic ctrl_access;
  logic mismatch;
  logic [6:0] code_x3;

  always_comb begin
    entry = CCL_MODE_TABLE[mode_ff];
    ctrl_access = (rd || wr) && (addr == CCL_ADDR_CTRL);
    mismatch = result_ff != seen_ff;
    code_x3 = {2'b00, ref_code_ff, 1'b0} + {3'b000, ref_code_ff};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_inv = inv_ff;
    nxt_switch = switch_ff;
    nxt_mode = mode_ff;
    nxt_ref_power = ref_power_ff;
    nxt_ref_range = ref_range_ff;
    nxt_ref_code = ref_code_ff;
    nxt_dir = dir_ff;
    nxt_ien = ien_ff;
    nxt_rdata = CCL_DATA_ZERO;

    // Register writes; the result bit of the control register is not writable
    if (wr) begin
      case (addr)
        CCL_ADDR_CTRL: begin
          nxt_inv = wdata[CCL_CTRL_INV];
          nxt_switch = wdata[CCL_CTRL_SWITCH];
          nxt_mode = wdata[CCL_CTRL_MODE_LSB +: 3];
        end
        CCL_ADDR_REF: begin
          nxt_ref_power = wdata[CCL_REF_POWER];
          nxt_ref_range = wdata[CCL_REF_RANGE];
          nxt_ref_code = wdata[CCL_REF_CODE_LSB +: 4];
        end
        CCL_ADDR_DIR: begin
          nxt_dir = wdata[5:0];
        end
        CCL_ADDR_IEN: begin
          nxt_ien = wdata[CCL_IRQ_CHANGE];
        end
        default: begin
          nxt_dir = dir_ff;
        end
      endcase
    end

    // Read data, valid only in the cycle after the strobe
    if (rd) begin
      case (addr)
        CCL_ADDR_CTRL: begin
          nxt_rdata = CCL_DATA_ZERO;
          nxt_rdata[CCL_CTRL_RESULT] = result_ff;
          nxt_rdata[CCL_CTRL_INV] = inv_ff;
          nxt_rdata[CCL_CTRL_SWITCH] = switch_ff;
          nxt_rdata[CCL_CTRL_MODE_LSB +: 3] = mode_ff;
        end
        CCL_ADDR_REF: begin
          nxt_rdata = CCL_DATA_ZERO;
          nxt_rdata[CCL_REF_POWER] = ref_power_ff;
          nxt_rdata[CCL_REF_RANGE] = ref_range_ff;
          nxt_rdata[CCL_REF_CODE_LSB +: 4] = ref_code_ff;
        end
        CCL_ADDR_DIR: begin
          nxt_rdata = {2'b00, dir_ff};
        end
        CCL_ADDR_PORT: begin
          // Analog pins have no digital input path, so they read as zero
          nxt_rdata = {2'b00, pin_in & ~{3'b000, entry[CCL_ENT_MASK_LSB +: 3]}};
        end
        CCL_ADDR_STAT: begin
          nxt_rdata = {7'h00, stat_ff};
        end
        CCL_ADDR_IEN: begin
          nxt_rdata = {7'h00, ien_ff};
        end
        default: begin
          nxt_rdata = CCL_DATA_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator result, change flag and interrupt
  always_comb begin
    // Raw is high when plus exceeds minus; an idle comparator reports zero
    nxt_result = entry[CCL_ENT_ON] & (compare_raw ^ inv_ff);
    // Any control access re-arms the reference copy and ends the mismatch
    nxt_seen = ctrl_access ? result_ff : seen_ff;
    nxt_stat = stat_ff;
    if (wr && (addr == CCL_ADDR_CLR) && wdata[CCL_IRQ_CHANGE]) begin
      nxt_stat = 1'b0;
    end
    // A standing mismatch keeps setting the flag and beats a clear
    if (mismatch) begin
      nxt_stat = 1'b1;
    end
    // Masking the flag during a mode change is up to software
    nxt_irq = nxt_stat & nxt_ien;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing and reference level
  always_comb begin
    nxt_on = entry[CCL_ENT_ON];
    nxt_plus = entry[CCL_ENT_PLUS_LSB +: 2];
    nxt_minus = entry[CCL_ENT_MINUS_LSB +: 2];
    if ((mode_ff == CCL_MODE_SWITCH_A) || (mode_ff == CCL_MODE_SWITCH_B)) begin
      nxt_minus = switch_ff ? CCL_SRC_PIN_ONE : CCL_SRC_PIN_TWO;
    end
    nxt_ref_conn = entry[CCL_ENT_REF];
    nxt_analog = entry[CCL_ENT_MASK_LSB +: 3];
    // Only one flop between comparator and pin; no clock-domain synchroniser
    nxt_pin = entry[CCL_ENT_OUT] & nxt_result;
    nxt_pin_oe = entry[CCL_ENT_OUT] & ~dir_ff[CCL_DIR_RESULT_PIN];
    // 16 codes in each of two ranges give 32 settings
    if (ref_range_ff) begin
      nxt_level = {1'b0, ref_code_ff, 2'b00};
    end else begin
      nxt_level = CCL_LEVEL_QUARTER + code_x3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      inv_ff <= 1'b0;
      switch_ff <= 1'b0;
      mode_ff <= CCL_MODE_RESET;
      ref_power_ff <= 1'b0;
      ref_range_ff <= 1'b0;
      ref_code_ff <= CCL_CODE_RESET;
      dir_ff <= CCL_DIR_RESET;
      stat_ff <= 1'b0;
      ien_ff <= 1'b0;
      rdata_ff <= CCL_DATA_ZERO;
      result_ff <= 1'b0;
      seen_ff <= 1'b0;
      on_ff <= 1'b0;
      plus_ff <= CCL_SRC_NONE;
      minus_ff <= CCL_SRC_NONE;
      ref_conn_ff <= 1'b0;
      level_ff <= CCL_LEVEL_QUARTER;
      analog_ff <= 3'h7;
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      inv_ff <= nxt_inv;
      switch_ff <= nxt_switch;
      mode_ff <= nxt_mode;
      ref_power_ff <= nxt_ref_power;
      ref_range_ff <= nxt_ref_range;
      ref_code_ff <= nxt_ref_code;
      dir_ff <= nxt_dir;
      stat_ff <= nxt_stat;
      ien_ff <= nxt_ien;
      rdata_ff <= nxt_rdata;
      result_ff <= nxt_result;
      seen_ff <= nxt_seen;
      on_ff <= nxt_on;
      plus_ff <= nxt_plus;
      minus_ff <= nxt_minus;
      ref_conn_ff <= nxt_ref_conn;
      level_ff <= nxt_level;
      analog_ff <= nxt_analog;
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wiring
  always_comb begin
    rdata = rdata_ff;
    comparator_on = on_ff;
    plus_sel = plus_ff;
    minus_sel = minus_ff;
    ref_connect = ref_conn_ff;
    reference_power_enable = ref_power_ff;
    reference_range_select = ref_range_ff;
    reference_level_code = ref_code_ff;
    internal_reference_level = level_ff;
    analog_pins = analog_ff;
    result_output_pin = pin_ff;
    result_output_pin_oe = pin_oe_ff;
    irq = irq_ff;
  end

endmodule

`default_nettype wire

// file: core/ccl_pkg.sv
// Register map, field layout, reset values and mode table of the comparator control block
package ccl_pkg;

  // Register byte offsets
  localparam logic [7:0] CCL_ADDR_CTRL = 8'h19;
  localparam logic [7:0] CCL_ADDR_REF = 8'h99;
  localparam logic [7:0] CCL_ADDR_DIR = 8'h85;
  localparam logic [7:0] CCL_ADDR_PORT = 8'h1d;
  localparam logic [7:0] CCL_ADDR_STAT = 8'h1a;
  localparam logic [7:0] CCL_ADDR_CLR = 8'h1b;
  localparam logic [7:0] CCL_ADDR_IEN = 8'h1c;

  // comparator_control fields
  localparam int CCL_CTRL_RESULT = 6;
  localparam int CCL_CTRL_INV = 4;
  localparam int CCL_CTRL_SWITCH = 3;
  localparam int CCL_CTRL_MODE_LSB = 0;

  // reference_control fields
  localparam int CCL_REF_POWER = 7;
  localparam int CCL_REF_RANGE = 5;
  localparam int CCL_REF_CODE_LSB = 0;

  // Status / enable / clear layout
  localparam int CCL_IRQ_CHANGE = 0;

  // Reset values
  localparam logic [2:0] CCL_MODE_RESET = 3'h0;
  localparam logic [3:0] CCL_CODE_RESET = 4'h0;
  localparam logic [5:0] CCL_DIR_RESET = 6'h3f;
  localparam logic [7:0] CCL_DATA_ZERO = 8'h00;

  // Switched-input modes
  localparam logic [2:0] CCL_MODE_SWITCH_A = 3'h6;
  localparam logic [2:0] CCL_MODE_SWITCH_B = 3'h5;

  // Input source codes
  localparam logic [1:0] CCL_SRC_PIN_ONE = 2'h0;
  localparam logic [1:0] CCL_SRC_PIN_TWO = 2'h1;
  localparam logic [1:0] CCL_SRC_REF = 2'h2;
  localparam logic [1:0] CCL_SRC_NONE = 2'h3;

  // Mode table entry: [9:7] analog pin mask, [6] on, [5] pin out, [4] ref, [3:2] +src, [1:0] -src
  localparam int CCL_ENT_MASK_LSB = 7;
  localparam int CCL_ENT_ON = 6;
  localparam int CCL_ENT_OUT = 5;
  localparam int CCL_ENT_REF = 4;
  localparam int CCL_ENT_PLUS_LSB = 2;
  localparam int CCL_ENT_MINUS_LSB = 0;
  localparam logic [9:0] CCL_MODE_TABLE [8] = '{
    10'h38f, 10'h1e1, 10'h1c1, 10'h0f2, 10'h0d2, 10'h1f9, 10'h1d9, 10'h00f
  };

  // Reference level is expressed in 96ths of the supply (common multiple of 24 and 32)
  localparam logic [6:0] CCL_LEVEL_QUARTER = 7'h18;
  localparam int CCL_DIR_RESULT_PIN = 2;

endpackage

// file: test/ccl_analog_model.sv
// Far side: analog input levels, reference tap and the result pin
`timescale 1ns/1ps
`default_nettype none
module ccl_analog_model (
  input wire logic clk,
  input wire logic [1:0] plus_sel,
  input wire logic [1:0] minus_sel,
  input wire logic ref_connect,
  input wire logic reference_power_enable,
  input wire logic [6:0] internal_reference_level,
  input wire logic result_output_pin,
  input wire logic result_output_pin_oe,
  input wire logic [6:0] level_one,
  input wire logic [6:0] level_two,
  input wire logic [5:0] pin_dig,
  output logic compare_raw,
  output logic [5:0] pin_in
);
  function automatic logic [6:0] src(input logic [1:0] s);
    case (s)
      2'h0: src = level_one;
      2'h1: src = level_two;
      2'h2: src = (ref_connect && reference_power_enable) ? internal_reference_level : 7'h00;
      default: src = 7'h00;
    endcase
  endfunction
  // Settles on the clock; an unpowered reference sits at ground
  always_ff @(posedge clk) begin
    compare_raw <= src(plus_sel) > src(minus_sel);
  end
  assign pin_in = {pin_dig[5:3], result_output_pin_oe ? result_output_pin : pin_dig[2],
    pin_dig[1:0]};
endmodule
`default_nettype wire

// file: test/ccl_comparator_control_properties.sv
// Port assertions for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module ccl_comparator_control_properties
  import ccl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic comparator_on,
  input wire logic [1:0] plus_sel,
  input wire logic [1:0] minus_sel,
  input wire logic ref_connect,
  input wire logic reference_power_enable,
  input wire logic reference_range_select,
  input wire logic [3:0] reference_level_code,
  input wire logic [6:0] internal_reference_level,
  input wire logic [2:0] analog_pins,
  input wire logic result_output_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_rd_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  chk_ctrl_spare: assert property ($past(rd) && $past(addr) == CCL_ADDR_CTRL
    |-> (rdata & 8'ha0) == 8'h00) else $error("spare control bits set");
  chk_clear_zero: assert property ($past(rd) && $past(addr) == CCL_ADDR_CLR
    |-> rdata == 8'h00) else $error("clear register readable");
  chk_port_analog: assert property ($past(rd) && $past(addr) == CCL_ADDR_PORT
    && $stable(analog_pins) |-> (rdata[2:0] & analog_pins) == 3'h0 && rdata[7:6] == 2'h0)
    else $error("analog pin not read as zero");
  // Level may trail a reference write by one cycle, so only stable settings are judged
  chk_ref_level: assert property ($stable(reference_range_select)
    && $stable(reference_level_code) |-> internal_reference_level == (reference_range_select
    ? {1'b0, reference_level_code, 2'b00} : {3'h0, reference_level_code} * 7'h03 + 7'h18))
    else $error("reference level wrong");
  chk_src_off: assert property (!comparator_on |-> plus_sel == CCL_SRC_NONE
    && minus_sel == CCL_SRC_NONE) else $error("source while off");
  chk_ref_route: assert property (ref_connect |-> plus_sel == CCL_SRC_REF
    || minus_sel == CCL_SRC_REF) else $error("reference not routed");
  chk_oe_on: assert property (result_output_pin_oe |-> comparator_on)
    else $error("pin driven while off");
  chk_reset_state: assert property (disable iff (1'b0) $past(rst)
    |-> !reference_power_enable && !comparator_on && analog_pins == 3'h7)
    else $error("reset state wrong");
endmodule
`default_nettype wire

// file: test/test_comparator_control_logic.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module test_comparator_control_logic;
  import ccl_pkg::*;
  typedef struct packed {logic [7:0] w; logic [8:0] e;} ccl_row_s;
  // Expect {plus, minus, ref, on, analog}; spare bits written to show they are ignored
  localparam ccl_row_s ROWS [10] = '{'{8'ha0, 9'h1e7}, '{8'ha1, 9'h02b}, '{8'h2a, 9'h02b},
    '{8'h83, 9'h059}, '{8'h34, 9'h059}, '{8'h05, 9'h13b}, '{8'h0d, 9'h11b},
    '{8'h06, 9'h13b}, '{8'h1e, 9'h11b}, '{8'h2f, 9'h1e0}};
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [6:0] level_one = 7'h10, level_two = 7'h20, internal_reference_level;
  logic [5:0] pin_dig = 6'h3f, pin_in;
  logic compare_raw, comparator_on, ref_connect, reference_power_enable, reference_range_select;
  logic result_output_pin, result_output_pin_oe, irq;
  logic [1:0] plus_sel, minus_sel;
  logic [3:0] reference_level_code;
  logic [2:0] analog_pins;
  logic [9:0] v;
  int n_errors = 0;
  int checks = 0;
  always #4 clk = ~clk;
  ccl_comparator_control uut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .compare_raw,
    .pin_in, .comparator_on, .plus_sel, .minus_sel, .ref_connect, .reference_power_enable,
    .reference_range_select, .reference_level_code, .internal_reference_level, .analog_pins,
    .result_output_pin, .result_output_pin_oe, .irq);
  ccl_analog_model far (.clk, .plus_sel, .minus_sel, .ref_connect, .reference_power_enable,
    .internal_reference_level, .result_output_pin, .result_output_pin_oe, .level_one,
    .level_two, .pin_dig, .compare_raw, .pin_in);
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = {2'h0, rdata};
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wt(2);
    chk({5'h00, irq, reference_power_enable, analog_pins}, 10'h007);
    rreg(CCL_ADDR_CTRL);
    chk(v, 10'h000);
    rreg(CCL_ADDR_REF);
    chk(v, 10'h000);
    rreg(CCL_ADDR_DIR);
    chk(v, 10'h03f);
    rreg(CCL_ADDR_PORT);
    chk(v, 10'h038);
    wreg(8'h00, 8'hff);
    rreg(8'h00);
    chk(v, 10'h000);
    $display("reset test done");
    foreach (ROWS[i]) begin
      wreg(CCL_ADDR_CTRL, ROWS[i].w);
      wt(2);
      chk({1'b0, plus_sel, minus_sel, ref_connect, comparator_on, analog_pins},
        {1'b0, ROWS[i].e});
      rreg(CCL_ADDR_CTRL);
      chk(v & 10'h0bf, {5'h00, ROWS[i].w[4:0]});
    end
    $display("mode table test done");
    wreg(CCL_ADDR_DIR, 8'h3b);
    wreg(CCL_ADDR_CTRL, 8'h01);
    level_one <= 7'h30;
    wt(5);
    chk({8'h00, result_output_pin, result_output_pin_oe}, 10'h003);
    wreg(CCL_ADDR_CTRL, 8'h11);
    wt(5);
    chk({9'h000, result_output_pin}, 10'h000);
    rreg(CCL_ADDR_CTRL);
    chk(v, 10'h011);
    @(posedge clk);
    level_one <= 7'h08;
    wt(5);
    rreg(CCL_ADDR_CTRL);
    chk(v, 10'h051);
    wreg(CCL_ADDR_DIR, 8'h3f);
    wt(3);
    chk({9'h000, result_output_pin_oe}, 10'h000);
    rreg(CCL_ADDR_PORT);
    chk(v, 10'h03c);
    $display("output pin test done");
    wreg(CCL_ADDR_CLR, 8'h01);
    wreg(CCL_ADDR_IEN, 8'h01);
    wt(3);
    chk({9'h000, irq}, 10'h000);
    level_one <= 7'h30;
    wt(5);
    chk({9'h000, irq}, 10'h001);
    wreg(CCL_ADDR_CLR, 8'h01);
    rreg(CCL_ADDR_STAT);
    chk(v, 10'h001);
    // Mismatch keeps setting the flag until a control access ends it
    rreg(CCL_ADDR_CTRL);
    chk(v, 10'h011);
    rreg(CCL_ADDR_CLR);
    chk(v, 10'h000);
    wreg(CCL_ADDR_CLR, 8'h01);
    wt(3);
    chk({9'h000, irq}, 10'h000);
    wreg(CCL_ADDR_IEN, 8'h00);
    level_one <= 7'h08;
    wt(5);
    rreg(CCL_ADDR_STAT);
    chk({v[8:0], irq}, 10'h002);
    $display("interrupt test done");
    for (int i = 0; i < 32; i++) begin
      wreg(CCL_ADDR_REF, {2'h3, i[4], 1'b1, i[3:0]});
      wt(2);
      chk({3'h0, internal_reference_level}, 10'(i[4] ? i[3:0] * 4 : 24 + i[3:0] * 3));
      rreg(CCL_ADDR_REF);
      chk(v, {3'h1, 1'b0, i[4], 1'b0, i[3:0]});
    end
    wreg(CCL_ADDR_REF, 8'h00);
    wt(2);
    chk({9'h000, reference_power_enable}, 10'h000);
    $display("reference test done");
    conclude();
  end
endmodule
bind ccl_comparator_control ccl_comparator_control_properties chk_i (.clk, .rst, .addr, .rd,
  .rdata, .comparator_on, .plus_sel, .minus_sel, .ref_connect, .reference_power_enable,
  .reference_range_select, .reference_level_code, .internal_reference_level, .analog_pins,
  .result_output_pin_oe);
`default_nettype wire
